// ---- i2cim_pkg.sv ----
// Constants shared by the two-wire interrupt enable/status block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`default_nettype none
package i2cim_pkg;
	// Register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_EVLOG = 8'h44;
	localparam logic [ADDR_W-1:0] OFF_EVMASK = 8'h48;
	// Enable register layout
	localparam int EN_W = 7;
	localparam int EN_AAS = 6;
	localparam logic [EN_W-1:0] EN_RESET = 7'h00;
	// Status register layout
	localparam int ST_W = 15;
	localparam int ST_AL = 0;
	localparam int ST_NACK = 1;
	localparam int ST_REGS_ACCESS_READY = 2;
	localparam int ST_RRDY = 3;
	localparam int ST_XRDY = 4;
	localparam int ST_SCD = 5;
	localparam int ST_AD0 = 8;
	localparam int ST_AAS = 9;
	localparam int ST_TX_SHIFT_EMPTY_N = 10;
	localparam int ST_RX_OVERRUN = 11;
	localparam int ST_BB = 12;
	localparam int ST_NOACK_SENT = 13;
	localparam int ST_SLAVE_DIRECTION = 14;
	localparam logic [ST_W-1:0] ST_W1C_MASK = 15'h703F;
	localparam logic [ST_W-1:0] ST_RESET = 15'h0410;
	// Control register layout
	localparam int CTRL_LOOP = 0;
	localparam logic CTRL_RESET = 1'b0;
	// Event log layout
	localparam int EV_W = 3;
	localparam int EV_OVR = 0;
	localparam int EV_BUSY = 1;
	localparam int EV_FREE = 2;
	localparam logic [EV_W-1:0] EV_RESET = 3'h0;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Write channel states
	typedef enum logic [1:0] {
		WS_IDLE = 2'b00,
		WS_ADDR = 2'b01,
		WS_DATA = 2'b10,
		WS_RESP = 2'b11
	} i2cim_wstate_type;
endpackage
`default_nettype wire

// ---- i2cim_reg_if.sv ----
// Register access strobes between the bus slave and the register file.
// Assumes both ends run on the same clock.
`default_nettype none
interface i2cim_reg_if;
	logic wr_en;
	logic [i2cim_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic rd_en;
	logic [i2cim_pkg::ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	modport bus(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_ok, rd_data, rd_ok);
	modport regs(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

// ---- i2cim_axil.sv ----
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes the register file answers decode and read data in one cycle.
`default_nettype none
module i2cim_axil (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels
	input wire logic [i2cim_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read channels
	input wire logic [i2cim_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side
	i2cim_reg_if.bus regs
);
	import i2cim_pkg::*;
	i2cim_wstate_type ws;
	i2cim_wstate_type next_ws;
	logic [ADDR_W-1:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	wire logic aw_take;
	wire logic w_take;
	wire logic ar_take;

	// Address and data may arrive in either order
	assign awready = (ws == WS_IDLE) || (ws == WS_DATA);
	assign wready = (ws == WS_IDLE) || (ws == WS_ADDR);
	assign aw_take = awvalid && awready;
	assign w_take = wvalid && wready;
	assign arready = !rvalid;
	assign ar_take = arvalid && arready;

	// Register strobes; the write fires once both halves are held
	assign regs.wr_en = (ws == WS_RESP) && !bvalid;
	assign regs.wr_addr = waddr_q;
	assign regs.wr_data = wdata_q;
	assign regs.wr_strb = wstrb_q;
	assign regs.rd_en = ar_take;
	assign regs.rd_addr = araddr;

	// Write state selection
	always_comb begin
		next_ws = ws;
		case (ws)
			WS_IDLE: begin
				if (aw_take && w_take) begin
					next_ws = WS_RESP;
				end else if (aw_take) begin
					next_ws = WS_ADDR;
				end else if (w_take) begin
					next_ws = WS_DATA;
				end
			end
			WS_ADDR: begin
				if (w_take) begin
					next_ws = WS_RESP;
				end
			end
			WS_DATA: begin
				if (aw_take) begin
					next_ws = WS_RESP;
				end
			end
			WS_RESP: begin
				if (bvalid && bready) begin
					next_ws = WS_IDLE;
				end
			end
			default: begin
				next_ws = WS_IDLE;
			end
		endcase
	end

	// Write channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ws <= WS_IDLE;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			ws <= next_ws;
			if (aw_take) begin
				waddr_q <= awaddr;
			end
			if (w_take) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (regs.wr_en) begin
				bvalid <= 1'b1;
				bresp <= regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read channel registers, one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid <= 1'b1;
			rdata <= regs.rd_data;
			rresp <= regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- i2cim_top.sv ----
// Interrupt enable and status registers of a two-wire bus controller.
// Assumes event strobes and levels come from the protocol engine on aclk.
`default_nettype none

module i2cim_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [i2cim_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [i2cim_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Event strobes from the protocol engine
	input wire logic ev_arb_lost,
	input wire logic ev_noack,
	input wire logic ev_regs_ready,
	input wire logic ev_rx_ready,
	input wire logic ev_tx_ready,
	input wire logic ev_start,
	input wire logic ev_stop,
	input wire logic ev_own_addr,
	input wire logic ev_general_call,
	input wire logic ev_noack_sent,
	input wire logic ev_slave_tx,
	// Levels from the protocol engine
	input wire logic rx_overrun,
	input wire logic tx_shift_empty_n,
	input wire logic address_zero_seen,
	// Outputs
	output logic digital_loopback,
	output logic bus_busy_flag,
	output logic slave_direction,
	output logic irq
);
	import i2cim_pkg::*;

	i2cim_reg_if rif();
	logic [EN_W-1:0] interrupt_enable;
	logic [ST_W-1:0] interrupt_status;
	logic [EV_W-1:0] event_log;
	logic [EV_W-1:0] event_mask;
	logic addressed_as_slave;
	logic ovr_prev;
	logic busy_prev;

	// Exact offset match, used by both the write and read decode
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	// Expands byte strobes to a bit mask
	function automatic logic [31:0] lanes(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	i2cim_axil u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.regs(rif.bus)
	);

	// Write decode and masked write data
	wire logic [31:0] wmask = lanes(rif.wr_strb);
	wire logic [31:0] wbits = rif.wr_data & wmask;
	wire logic wr_en_reg = rif.wr_en && hit(rif.wr_addr, OFF_ENABLE);
	wire logic wr_st_reg = rif.wr_en && hit(rif.wr_addr, OFF_STATUS);
	wire logic wr_ctrl = rif.wr_en && hit(rif.wr_addr, OFF_CTRL);
	wire logic wr_evmask = rif.wr_en && hit(rif.wr_addr, OFF_EVMASK);
	assign rif.wr_ok = hit(rif.wr_addr, OFF_ENABLE) ||
		hit(rif.wr_addr, OFF_STATUS) || hit(rif.wr_addr, OFF_CTRL) ||
		hit(rif.wr_addr, OFF_EVLOG) || hit(rif.wr_addr, OFF_EVMASK);

	// Only the seven enable bits are stored; upper bits are dropped
	wire logic [EN_W-1:0] next_enable = wr_en_reg ?
		((interrupt_enable & ~wmask[EN_W-1:0]) |
		wbits[EN_W-1:0]) : interrupt_enable;

	// Software clear: ones written to clearable positions only
	wire logic [ST_W-1:0] sw_clr = wr_st_reg ?
		(wbits[ST_W-1:0] & ST_W1C_MASK) : '0;

	// Hardware set terms; loopback blocks the slave direction flag
	wire logic slave_direction_set = ev_slave_tx && !digital_loopback;
	wire logic [ST_W-1:0] hw_set = {slave_direction_set, ev_noack_sent, ev_start,
		6'h00, ev_stop, ev_tx_ready, ev_rx_ready, ev_regs_ready,
		ev_noack, ev_arb_lost};

	// Hardware clear terms: START or STOP ends slave direction, STOP alone ends busy
	wire logic [ST_W-1:0] hw_clr = {ev_start || ev_stop, 1'b0, ev_stop,
		12'h000};

	// Clearable part: set wins over any clear in the same cycle
	wire logic [ST_W-1:0] w1c_next = ((interrupt_status & ~sw_clr &
		~hw_clr) | hw_set) & ST_W1C_MASK;

	// Read-only part follows the engine only; writes never reach it
	wire logic [ST_W-1:0] ro_next = {3'h0, rx_overrun, tx_shift_empty_n,
		addressed_as_slave, address_zero_seen, 8'h00};

	// Loopback holds slave direction low whatever else happens
	wire logic [ST_W-1:0] loop_mask = {!digital_loopback, 14'h3FFF};
	wire logic [ST_W-1:0] next_status =
		(w1c_next | ro_next) & loop_mask;

	// Address match or general call marks the controller as addressed
	wire logic next_aas = ev_own_addr || ev_general_call ||
		(addressed_as_slave && !ev_stop);

	// Event log: overrun onset, bus going busy, bus going free
	wire logic [EV_W-1:0] ev_now = {busy_prev && !interrupt_status[ST_BB],
		!busy_prev && interrupt_status[ST_BB], rx_overrun && !ovr_prev};
	wire logic rd_evlog = rif.rd_en && hit(rif.rd_addr, OFF_EVLOG);
	wire logic [EV_W-1:0] next_evlog =
		(event_log & ~{EV_W{rd_evlog}}) | ev_now;

	// Request sources in enable-bit order
	wire logic [EN_W-1:0] src = {interrupt_status[ST_AAS],
		interrupt_status[ST_SCD:ST_AL]};
	wire logic [EN_W-1:0] req = src & interrupt_enable;
	wire logic next_irq = (|req) || (|(event_log & event_mask));

	// Enable, status and addressed-as-slave registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_enable <= EN_RESET;
			interrupt_status <= ST_RESET;
			addressed_as_slave <= 1'b0;
		end else begin
			interrupt_enable <= next_enable;
			interrupt_status <= next_status;
			addressed_as_slave <= next_aas;
		end
	end

	// Control, event log and interrupt output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			digital_loopback <= CTRL_RESET;
			event_log <= EV_RESET;
			event_mask <= EV_RESET;
			ovr_prev <= 1'b0;
			busy_prev <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (wr_ctrl && wmask[CTRL_LOOP]) begin
				digital_loopback <= rif.wr_data[CTRL_LOOP];
			end
			if (wr_evmask) begin
				event_mask <= (event_mask & ~wmask[EV_W-1:0]) |
					wbits[EV_W-1:0];
			end
			event_log <= next_evlog;
			ovr_prev <= rx_overrun;
			busy_prev <= interrupt_status[ST_BB];
			irq <= next_irq;
		end
	end

	// Status views for the engine
	assign bus_busy_flag = interrupt_status[ST_BB];
	assign slave_direction = interrupt_status[ST_SLAVE_DIRECTION];

	// Read mux; unmapped offsets answer an error with zero data
	wire logic rd_is_en = hit(rif.rd_addr, OFF_ENABLE);
	wire logic rd_is_st = hit(rif.rd_addr, OFF_STATUS);
	wire logic rd_is_ctrl = hit(rif.rd_addr, OFF_CTRL);
	wire logic rd_is_evl = hit(rif.rd_addr, OFF_EVLOG);
	wire logic rd_is_evm = hit(rif.rd_addr, OFF_EVMASK);
	assign rif.rd_ok = rd_is_en || rd_is_st || rd_is_ctrl ||
		rd_is_evl || rd_is_evm;
	assign rif.rd_data = rd_is_en ? 32'(interrupt_enable) :
		rd_is_st ? 32'(interrupt_status) :
		rd_is_ctrl ? 32'(digital_loopback) :
		rd_is_evl ? 32'(event_log) :
		rd_is_evm ? 32'(event_mask) : 32'h0000_0000;

	// Checks on the register behaviour
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_reserved_zero: assert property (
		rif.rd_en && (rd_is_en || rd_is_st) |->
		rif.rd_data[31:ST_W] == '0 && (!rd_is_en ||
		rif.rd_data[ST_W-1:EN_W] == '0))
		else $error("reserved bits read non-zero");

	for (genvar g = 0; g < EN_W; g++) begin : gen_gate
		chk_source_gate: assert property (
			src[g] && interrupt_enable[g] |=> irq)
			else $error("enabled source did not raise irq");
		chk_source_block: assert property (
			!interrupt_enable[g] && src == (EN_W'(1) << g) &&
			(event_log & event_mask) == '0 |=> !irq)
			else $error("disabled source raised irq");
	end

	chk_w1c_clear: assert property (
		wr_st_reg && wbits[ST_NACK] && !ev_noack
		|=> !interrupt_status[ST_NACK])
		else $error("write one did not clear flag");

	chk_w1c_keep: assert property (
		wr_st_reg && !wbits[ST_REGS_ACCESS_READY] && interrupt_status[ST_REGS_ACCESS_READY]
		|=> interrupt_status[ST_REGS_ACCESS_READY])
		else $error("write zero cleared flag");

	chk_slave_direction_loop: assert property (
		digital_loopback |=> !slave_direction)
		else $error("slave direction set in loopback");

	chk_slave_direction_set: assert property (
		ev_slave_tx && !digital_loopback |=> slave_direction[*2] or
		(slave_direction ##1 !slave_direction))
		else $error("slave transmit did not set direction");

	chk_slave_direction_auto: assert property (
		(ev_start || ev_stop) && !ev_slave_tx |=> !slave_direction)
		else $error("start or stop left direction set");

	chk_aas_set: assert property (
		ev_own_addr || ev_general_call |=> ##1 interrupt_status[ST_AAS])
		else $error("address match not flagged");

	chk_regs_access_ready_set: assert property (
		ev_regs_ready |=> interrupt_status[ST_REGS_ACCESS_READY])
		else $error("registers ready not flagged");

	chk_irq_level: assert property (
		irq == $past(next_irq))
		else $error("irq does not follow enabled flags");

	chk_ro_bits: assert property (
		wr_st_reg |=> interrupt_status[ST_RX_OVERRUN] == $past(rx_overrun) &&
		interrupt_status[ST_TX_SHIFT_EMPTY_N] == $past(tx_shift_empty_n))
		else $error("read-only status bit took a write");

	// Main scenarios
	cov_w1c_write: cover property (wr_st_reg ##1 interrupt_status == '0);
	cov_irq_rise: cover property (!irq ##1 irq);
	cov_addressed: cover property (ev_general_call ##2 irq);
	cov_evlog_read: cover property (rd_evlog && event_log != '0);
endmodule
`default_nettype wire

// ---- i2cim_engine_model.sv ----
// Stand-in for the protocol engine: event strobes and status levels.
// Assumes the bench holds a request bit high for at least one cycle.
`default_nettype none
module i2cim_engine_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Requests from the bench
	input wire logic [10:0] req,
	input wire logic [2:0] lvl_req,
	// Event strobes and levels toward the block
	output logic [10:0] ev,
	output logic [2:0] lv
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0] req_q;
	// One-cycle strobe per rising request, so a held request fires once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_q <= 11'h000;
			ev <= 11'h000;
		end else begin
			req_q <= req;
			ev <= req & ~req_q;
		end
		lv <= lvl_req;
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the interrupt enable and status registers.
// Assumes the engine model drives events; AXI4-Lite master is local.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import i2cim_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic ev_arb_lost, ev_noack, ev_regs_ready, ev_rx_ready, ev_tx_ready;
	logic ev_start, ev_stop, ev_own_addr, ev_general_call, ev_noack_sent;
	logic ev_slave_tx, rx_overrun, tx_shift_empty_n, address_zero_seen;
	logic digital_loopback, bus_busy_flag, slave_direction, irq;
	logic [10:0] ev_req = '0, ev;
	logic [2:0] lvl_req = 3'b010, lv;
	int mismatches = 0, n_checks = 0, cyc = 0;
	// Rows: event index, status bit it sets, enable bit that gates it
	int rows [8][3] = '{'{0, 0, 0}, '{1, 1, 1}, '{2, 2, 2}, '{3, 3, 3},
		'{4, 4, 4}, '{5, 5, 5}, '{7, 9, 6}, '{8, 9, 6}};

	// Unpack model vectors onto the named event and level inputs
	assign {ev_slave_tx, ev_noack_sent, ev_general_call, ev_own_addr,
		ev_start, ev_stop, ev_tx_ready, ev_rx_ready, ev_regs_ready,
		ev_noack, ev_arb_lost} = ev;
	assign {address_zero_seen, tx_shift_empty_n, rx_overrun} = lv;

	i2cim_top dut_u (.*);
	i2cim_engine_model eng_u (.aclk(aclk), .aresetn(aresetn), .req(ev_req),
		.lvl_req(lvl_req), .ev(ev), .lv(lv));

	// 50 MHz clock
	always #10 aclk = ~aclk;

	// Hang guard: counts as a mismatch and closes the run
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Write: address and data offered together, each dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask

	// Read: rready held until rvalid is seen at an edge
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string m);
		axr(a);
		chk(rd, e, m);
	endtask

	// Ask the engine model for one event strobe and let it settle
	task automatic fire(input int i);
		@(posedge aclk);
		ev_req[i] <= 1'b1;
		@(posedge aclk);
		ev_req[i] <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(OFF_ENABLE, 32'h0000_0000, "enable reset");
		rdc(OFF_STATUS, 32'h0000_0410, "status reset");
		chk(32'(irq), 32'h0000_0000, "irq reset");
		axw(OFF_ENABLE, 32'hFFFF_FFFF);
		rdc(OFF_ENABLE, 32'h0000_007F, "enable upper");
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0000_0001, "tx ready irq");
		axw(OFF_ENABLE, 32'h0000_0000);
		axw(OFF_STATUS, 32'hFFFF_8000);
		rdc(OFF_STATUS, 32'h0000_0410, "status upper");
		$display("test reset done");
		// Each source alone, gated only by its own enable bit
		foreach (rows[r]) begin
			fire(5);
			axw(OFF_STATUS, 32'h0000_703F);
			rdc(OFF_STATUS, 32'h0000_0400, "flags cleared");
			fire(rows[r][0]);
			axw(OFF_STATUS, 32'h0000_0000);
			rdc(OFF_STATUS, 32'h0000_0400 | (32'h1 << rows[r][1]),
				"flag set");
			axw(OFF_ENABLE, ~(32'h1 << rows[r][2]) & 32'h0000_007F);
			repeat (2) @(posedge aclk);
			chk(32'(irq), 32'h0000_0000, "blocked");
			axw(OFF_ENABLE, 32'h1 << rows[r][2]);
			repeat (2) @(posedge aclk);
			chk(32'(irq), 32'h0000_0001, "passed");
			axw(OFF_ENABLE, 32'h0000_0000);
		end
		$display("test sources done");
		// Slave direction: set, write-zero, START, STOP, write-one, loopback
		fire(5);
		axw(OFF_STATUS, 32'h0000_703F);
		fire(10);
		rdc(OFF_STATUS, 32'h0000_4400, "slave_direction set");
		chk(32'(slave_direction), 32'h0000_0001, "slave_direction pin");
		axw(OFF_STATUS, 32'h0000_0000);
		fire(6);
		rdc(OFF_STATUS, 32'h0000_1400, "start clears");
		chk(32'(bus_busy_flag), 32'h0000_0001, "busy pin");
		fire(10);
		fire(5);
		rdc(OFF_STATUS, 32'h0000_0420, "stop clears");
		fire(10);
		axw(OFF_STATUS, 32'h0000_4000);
		rdc(OFF_STATUS, 32'h0000_0420, "slave_direction w1c");
		axw(OFF_CTRL, 32'h0000_0001);
		chk(32'(digital_loopback), 32'h0000_0001, "loopback pin");
		fire(10);
		rdc(OFF_STATUS, 32'h0000_0420, "loopback slave_direction");
		axw(OFF_CTRL, 32'h0000_0000);
		fire(9);
		rdc(OFF_STATUS, 32'h0000_2420, "noack sent");
		axw(OFF_STATUS, 32'h0000_2000);
		$display("test direction done");
		// Read-only bits follow levels and ignore writes
		@(posedge aclk);
		lvl_req <= 3'b101;
		axw(OFF_STATUS, 32'h0000_0F00);
		rdc(OFF_STATUS, 32'h0000_0920, "read-only bits");
		lvl_req <= 3'b010;
		// Event log: busy rise, busy fall and overrun onset all logged
		axw(OFF_EVMASK, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0000_0001, "evlog irq");
		rdc(OFF_EVMASK, 32'h0000_0001, "evmask");
		rdc(OFF_EVLOG, 32'h0000_0007, "evlog");
		rdc(OFF_EVLOG, 32'h0000_0000, "evlog cleared");
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0000_0000, "evlog irq off");
		axw(OFF_EVMASK, 32'h0000_0000);
		// Unmapped offset
		axr(8'h10);
		chk(rd, 32'h0000_0000, "unmapped data");
		chk(32'(resp), 32'(RESP_SLVERR), "unmapped read");
		axw(8'h10, 32'hFFFF_FFFF);
		chk(32'(resp), 32'(RESP_SLVERR), "unmapped write");
		$display("test misc done");
		// Second reset in mid-run
		axw(OFF_ENABLE, 32'h0000_007F);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(OFF_ENABLE, 32'h0000_0000, "enable re-reset");
		rdc(OFF_STATUS, 32'h0000_0410, "status re-reset");
		$display("test rereset done");
		finish_test();
	end
endmodule
`default_nettype wire
